// ### rtl/prst_pkg.sv
// Shared constants and types for the printer offline self-test block
package prst_pkg;

    // Printable code range
    localparam logic [6:0] CODE_FIRST = 7'h20;
    localparam logic [6:0] CODE_LAST = 7'h7e;
    localparam int unsigned CODE_SPAN = 95;

    // Overprint passes on every other line
    localparam logic [5:0] OVERPRINT_PASSES = 6'h21;

    // Switch toggle counts that select paper width
    localparam logic [1:0] TOGGLES_NARROW = 2'h1;
    localparam logic [1:0] TOGGLES_WIDE = 2'h2;

    // Default columns per line
    localparam int unsigned COLS_NARROW_NORM = 80;
    localparam int unsigned COLS_NARROW_COMP = 132;
    localparam int unsigned COLS_WIDE_NORM = 132;
    localparam int unsigned COLS_WIDE_COMP = 220;

    // Buffer shape
    localparam int unsigned FIFO_DEPTH = 16;

    // Register byte offsets
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_LINES = 4'h8;
    localparam logic [3:0] OFS_POSITION = 4'hc;

    // Control register fields and reset value
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_RUN_RESET = 1'b1;

    // Status register field positions
    localparam int unsigned STS_STATE_LSB = 0;
    localparam int unsigned STS_TOGGLE_LSB = 4;
    localparam int unsigned STS_OVER_BIT = 6;
    localparam int unsigned STS_WIDE_BIT = 7;
    localparam int unsigned STS_REV_BIT = 8;
    localparam int unsigned STS_LEVEL_LSB = 12;

    // Position register field positions
    localparam int unsigned POS_START_LSB = 0;
    localparam int unsigned POS_CODE_LSB = 8;
    localparam int unsigned POS_COL_LSB = 16;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_CHAR = 4'h4,
        ST_EOL = 4'h8
    } prst_state_type;

    typedef enum logic [1:0] {
        KIND_CHAR = 2'h0,
        KIND_RETURN = 2'h1,
        KIND_FEED = 2'h2
    } prst_kind_type;

    // One item for the print mechanism
    typedef struct packed {
        prst_kind_type kind;
        logic [6:0] code;
        logic reverse;
        logic compressed;
        logic alt_set;
        logic lpi8;
        logic wide;
    } prst_item_type;

    localparam int unsigned ITEM_W = $bits(prst_item_type);

    // Self-test switch: toward run, or held in overprint position
    typedef struct packed {
        logic overprint_pos;
        logic run_toggle;
    } prst_switch_type;

endpackage

// ### rtl/prst_fifo.sv
// Parameterised first-in first-out buffer with flush
module prst_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int unsigned PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
        $error("prst_fifo depth must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_width_check
        $error("prst_fifo width must be at least 1");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } prst_fifo_state_type;

    prst_fifo_state_type s_reg;
    prst_fifo_state_type s_next;
    logic push;
    logic pop;

    assign in_ready = (s_reg.cnt != (PW + 1)'(DEPTH));
    assign out_valid = (s_reg.cnt != '0);
    assign out_data = s_reg.mem[s_reg.rd];
    assign level = s_reg.cnt;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
        // Flush drops queued items; memory contents are left stale
        if (flush) begin
            s_next.wr = '0;
            s_next.rd = '0;
            s_next.cnt = '0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ### rtl/prst_self_test.sv
// Offline self-test sequencer feeding the print mechanism
// Summary of operation
// - Arming counts switch toggles only while offline; no host path is used.
// - Characters come from an internal generator, never from received data.
// - A rotating character pattern prints in normal or compressed pitch.
// - Panel spacing, pitch and glyph table settings travel with every item.
// - One toggle after clear selects narrow paper, two select wide paper.
// - Overprint position makes every other line print 33 times before feed.
// - Once armed, printing starts as soon as the printer goes online, if the control register run bit is set.
// - Only master clear or a control register clear write ends the test; the sequence otherwise repeats forever.
// - Codes run from space, 20 hex, through tilde, 7e hex.
// - Successive passes alternate carriage direction.
module prst_self_test #(
    parameter int unsigned COLS_NN = prst_pkg::COLS_NARROW_NORM,
    parameter int unsigned COLS_NC = prst_pkg::COLS_NARROW_COMP,
    parameter int unsigned COLS_WN = prst_pkg::COLS_WIDE_NORM,
    parameter int unsigned COLS_WC = prst_pkg::COLS_WIDE_COMP,
    parameter int unsigned DEPTH = prst_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Operator panel
    input wire logic master_clear_button,
    input wire logic online_switch,
    input wire prst_pkg::prst_switch_type diag_run_overprint_switch,
    input wire logic pitch_select_switch,
    input wire logic glyph_table_select_switch,
    input wire logic line_spacing_switch,
    // Avalon-MM register slave
    input wire logic [prst_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Item stream to the print mechanism
    output logic item_valid,
    input wire logic item_ready,
    output prst_pkg::prst_item_type item_data,
    // Test running indicator
    output logic test_active
);
    if (COLS_NN < 1 || COLS_NN > 255 || COLS_NC < 1 || COLS_NC > 255 ||
        COLS_WN < 1 || COLS_WN > 255 || COLS_WC < 1 || COLS_WC > 255)
    begin : g_cols_check
        $error("prst_self_test columns per line must be 1 to 255");
    end

    typedef struct packed {
        prst_pkg::prst_state_type state;
        logic [1:0] toggles;
        logic sw_prev;
        logic overprint;
        logic wide;
        logic [6:0] start_code;
        logic [6:0] code;
        logic [7:0] col;
        logic [5:0] pass;
        logic line_odd;
        logic reverse;
        logic [15:0] lines;
        logic run_permit;
        logic ack;
        logic [31:0] rdata;
    } prst_seq_state_type;

    prst_seq_state_type s_reg;
    prst_seq_state_type s_next;

    prst_pkg::prst_item_type gen_item;
    logic gen_valid;
    logic gen_ready;
    logic push;
    logic clear_all;
    logic soft_clear;
    logic [7:0] ncols;
    logic [$clog2(DEPTH):0] fifo_level;
    logic access;
    logic write_now;

    // First code of a pass in the chosen direction
    function automatic logic [6:0] first_code(input logic [6:0] start,
                                              input logic rev,
                                              input logic [7:0] n);
        int unsigned off;
        off = (int'(start - prst_pkg::CODE_FIRST) + int'(n) - 1) %
              prst_pkg::CODE_SPAN;
        if (rev) begin
            return prst_pkg::CODE_FIRST + 7'(off);
        end
        return start;
    endfunction

    // Step one code up or down inside the printable range
    function automatic logic [6:0] step_code(input logic [6:0] c,
                                             input logic down);
        if (down) begin
            return (c == prst_pkg::CODE_FIRST) ? prst_pkg::CODE_LAST :
                                                  c - 7'h01;
        end
        return (c == prst_pkg::CODE_LAST) ? prst_pkg::CODE_FIRST :
                                             c + 7'h01;
    endfunction

    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & ~s_reg.ack;
    assign avs_readdata = s_reg.rdata;
    assign write_now = avs_write & s_reg.ack;
    assign soft_clear = write_now & (avs_address == prst_pkg::OFS_CTRL) &
                        avs_writedata[prst_pkg::CTRL_CLEAR_BIT];
    assign clear_all = master_clear_button | soft_clear;
    assign test_active = s_reg.state == prst_pkg::ST_CHAR ||
                         s_reg.state == prst_pkg::ST_EOL;

    // Line length follows paper width and pitch
    always_comb begin
        if (s_reg.wide) begin
            ncols = pitch_select_switch ? 8'(COLS_WC) : 8'(COLS_WN);
        end else begin
            ncols = pitch_select_switch ? 8'(COLS_NC) : 8'(COLS_NN);
        end
    end

    // Item offered to the buffer
    always_comb begin
        gen_item.code = s_reg.code;
        gen_item.reverse = s_reg.reverse;
        gen_item.compressed = pitch_select_switch;
        gen_item.alt_set = glyph_table_select_switch;
        gen_item.lpi8 = line_spacing_switch;
        gen_item.wide = s_reg.wide;
        if (s_reg.state == prst_pkg::ST_EOL && s_reg.overprint &&
            s_reg.line_odd &&
            s_reg.pass != prst_pkg::OVERPRINT_PASSES - 6'h01) begin
            gen_item.kind = prst_pkg::KIND_RETURN;
        end else if (s_reg.state == prst_pkg::ST_EOL) begin
            gen_item.kind = prst_pkg::KIND_FEED;
        end else begin
            gen_item.kind = prst_pkg::KIND_CHAR;
        end
    end

    // Run permit pauses generation without losing position
    assign gen_valid = test_active & s_reg.run_permit & ~clear_all;
    assign push = gen_valid & gen_ready;

    always_comb begin
        logic [6:0] nstart;
        logic nrev;
        nstart = step_code(s_reg.start_code, 1'b0);
        nrev = ~s_reg.reverse;
        s_next = s_reg;
        s_next.sw_prev = diag_run_overprint_switch.run_toggle;

        // Register bus: one wait state on every access
        s_next.ack = access & ~s_reg.ack;
        if (avs_read && !s_reg.ack) begin
            s_next.rdata = '0;
            if (avs_address == prst_pkg::OFS_CTRL) begin
                s_next.rdata[prst_pkg::CTRL_RUN_BIT] = s_reg.run_permit;
            end else if (avs_address == prst_pkg::OFS_STATUS) begin
                s_next.rdata[prst_pkg::STS_STATE_LSB +: 4] = s_reg.state;
                s_next.rdata[prst_pkg::STS_TOGGLE_LSB +: 2] = s_reg.toggles;
                s_next.rdata[prst_pkg::STS_OVER_BIT] = s_reg.overprint;
                s_next.rdata[prst_pkg::STS_WIDE_BIT] = s_reg.wide;
                s_next.rdata[prst_pkg::STS_REV_BIT] = s_reg.reverse;
                s_next.rdata[prst_pkg::STS_LEVEL_LSB +: $bits(fifo_level)] =
                    fifo_level;
            end else if (avs_address == prst_pkg::OFS_LINES) begin
                s_next.rdata[15:0] = s_reg.lines;
            end else if (avs_address == prst_pkg::OFS_POSITION) begin
                s_next.rdata[prst_pkg::POS_START_LSB +: 7] = s_reg.start_code;
                s_next.rdata[prst_pkg::POS_CODE_LSB +: 7] = s_reg.code;
                s_next.rdata[prst_pkg::POS_COL_LSB +: 8] = s_reg.col;
            end
        end
        if (write_now && avs_address == prst_pkg::OFS_CTRL) begin
            s_next.run_permit = avs_writedata[prst_pkg::CTRL_RUN_BIT];
        end

        case (s_reg.state)
            prst_pkg::ST_IDLE: begin
                // Online printer ignores the switch entirely
                if (!online_switch && diag_run_overprint_switch.run_toggle &&
                    !s_reg.sw_prev) begin
                    s_next.toggles = prst_pkg::TOGGLES_NARROW;
                    s_next.state = prst_pkg::ST_ARMED;
                end
            end
            prst_pkg::ST_ARMED: begin
                if (diag_run_overprint_switch.run_toggle && !s_reg.sw_prev &&
                    !online_switch) begin
                    s_next.toggles = prst_pkg::TOGGLES_WIDE;
                end
                if (diag_run_overprint_switch.overprint_pos) begin
                    s_next.overprint = 1'b1;
                end
                if (online_switch) begin
                    s_next.state = prst_pkg::ST_CHAR;
                    s_next.wide = s_reg.toggles == prst_pkg::TOGGLES_WIDE;
                    s_next.overprint = s_reg.overprint |
                        diag_run_overprint_switch.overprint_pos;
                    s_next.start_code = prst_pkg::CODE_FIRST;
                    s_next.code = prst_pkg::CODE_FIRST;
                    s_next.col = '0;
                    s_next.pass = '0;
                    s_next.line_odd = 1'b0;
                    s_next.reverse = 1'b0;
                    s_next.lines = '0;
                end
            end
            prst_pkg::ST_CHAR: begin
                if (push) begin
                    s_next.code = step_code(s_reg.code, s_reg.reverse);
                    s_next.col = s_reg.col + 8'h01;
                    if (s_reg.col >= ncols - 8'h01) begin
                        s_next.state = prst_pkg::ST_EOL;
                    end
                end
            end
            prst_pkg::ST_EOL: begin
                if (push) begin
                    s_next.state = prst_pkg::ST_CHAR;
                    s_next.col = '0;
                    s_next.reverse = nrev;
                    if (gen_item.kind == prst_pkg::KIND_RETURN) begin
                        s_next.pass = s_reg.pass + 6'h01;
                        s_next.code = first_code(s_reg.start_code, nrev,
                                                 ncols);
                    end else begin
                        s_next.pass = '0;
                        s_next.line_odd = ~s_reg.line_odd;
                        s_next.lines = s_reg.lines + 16'h0001;
                        s_next.start_code = nstart;
                        s_next.code = first_code(nstart, nrev,
                                                 ncols);
                    end
                end
            end
            default: begin
                s_next.state = prst_pkg::ST_IDLE;
            end
        endcase

        // Master clear or a control register clear write is the only way out of a running test
        if (clear_all) begin
            s_next.state = prst_pkg::ST_IDLE;
            s_next.toggles = '0;
            s_next.overprint = 1'b0;
            s_next.wide = 1'b0;
            s_next.col = '0;
            s_next.pass = '0;
            s_next.reverse = 1'b0;
            s_next.line_odd = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '{state: prst_pkg::ST_IDLE,
                       start_code: prst_pkg::CODE_FIRST,
                       code: prst_pkg::CODE_FIRST,
                       run_permit: prst_pkg::CTRL_RUN_RESET,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Buffer decouples generator from carriage speed
    prst_fifo #(
        .WIDTH(prst_pkg::ITEM_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(clear_all),
        .in_valid(gen_valid),
        .in_ready(gen_ready),
        .in_data(gen_item),
        .out_valid(item_valid),
        .out_ready(item_ready),
        .out_data(item_data),
        .level(fifo_level)
    );
endmodule

// ### test/prst_checker.sv
// Port-level assertions for the offline self-test block
module prst_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Operator panel
    input wire logic master_clear_button,
    input wire logic online_switch,
    // Register bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Item stream
    input wire logic item_valid,
    input wire logic item_ready,
    input wire prst_pkg::prst_item_type item_data,
    input wire logic test_active
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_req_rise;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // Clears may legally drop a stalled item
    sequence s_stall;
        item_valid && !item_ready && !master_clear_button && !avs_write;
    endsequence

    chk_one_wait_state: assert property (s_req_rise |-> s_one_wait)
        else $error("bus answer not after exactly one wait state");
    chk_idle_bus_free: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    chk_stall_hold: assert property (
        s_stall |=> item_valid && $stable(item_data))
        else $error("item changed while stalled");
    chk_code_range: assert property (
        item_valid && item_data.kind == prst_pkg::KIND_CHAR |->
        item_data.code >= prst_pkg::CODE_FIRST &&
        item_data.code <= prst_pkg::CODE_LAST)
        else $error("character code outside printable range");
    chk_kind_legal: assert property (item_valid |->
        item_data.kind inside {prst_pkg::KIND_CHAR, prst_pkg::KIND_RETURN,
        prst_pkg::KIND_FEED})
        else $error("illegal item kind");
    chk_clear_idles: assert property (
        master_clear_button |=> !test_active && !item_valid)
        else $error("master clear did not stop the test");
    chk_start_online: assert property (
        $rose(test_active) |-> $past(online_switch))
        else $error("test started while offline");
    chk_first_item: assert property (
        $rose(test_active) |-> ##[0:2] item_valid)
        else $error("first item late after going online");
    chk_items_active: assert property (item_valid |-> test_active)
        else $error("item offered outside the test");
endmodule

// ### test/prst_mech_model.sv
// Print mechanism model: takes items with random stalls
module prst_mech_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Bench stall request
    input wire logic hold_off,
    // Item stream
    output logic item_ready
);
    logic [15:0] rnd_reg;
    // Ready does not wait for valid, so stalls land at any point
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rnd_reg <= 16'h1d2b;
            item_ready <= 1'b0;
        end else begin
            rnd_reg <= {rnd_reg[14:0],
                rnd_reg[15] ^ rnd_reg[13] ^ rnd_reg[12] ^ rnd_reg[10]};
            item_ready <= !hold_off && rnd_reg[0];
        end
    end
endmodule

// ### test/prst_self_test_tb_top.sv
// Self-checking bench for the offline self-test block
module prst_self_test_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Short lines keep a full code wrap within a brief run
    localparam int unsigned C_NN = 3;
    localparam int unsigned C_NC = 5;
    localparam int unsigned C_WN = 7;
    localparam int unsigned C_WC = 11;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic master_clear_button = 1'b0;
    logic online_switch = 1'b0;
    prst_pkg::prst_switch_type diag_run_overprint_switch = '0;
    logic pitch_select_switch = 1'b0;
    logic glyph_table_select_switch = 1'b0;
    logic line_spacing_switch = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, item_valid, item_ready, test_active;
    logic hold_off = 1'b1;
    logic checking = 1'b0;
    prst_pkg::prst_item_type item_data, ex;
    int fails = 0;
    int tests_run = 0;
    int got = 0;
    int e_col, e_line, e_pass, ncols;
    logic [6:0] e_start;
    logic e_rev, e_over, e_wide;
    logic [31:0] rnd = 32'd99;
    logic [31:0] rd;

    prst_self_test #(.COLS_NN(C_NN), .COLS_NC(C_NC), .COLS_WN(C_WN),
        .COLS_WC(C_WC), .DEPTH(prst_pkg::FIFO_DEPTH)) prst_self_test_i (
        .mclk(mclk), .sys_rst(sys_rst),
        .master_clear_button(master_clear_button),
        .online_switch(online_switch),
        .diag_run_overprint_switch(diag_run_overprint_switch),
        .pitch_select_switch(pitch_select_switch),
        .glyph_table_select_switch(glyph_table_select_switch),
        .line_spacing_switch(line_spacing_switch),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .item_valid(item_valid), .item_ready(item_ready),
        .item_data(item_data), .test_active(test_active));
    prst_mech_model prst_mech_model_i (.mclk(mclk), .sys_rst(sys_rst),
        .hold_off(hold_off), .item_ready(item_ready));

    initial forever #25 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [6:0] wrap_code(input int x);
        return 7'(32 + (x - 32) % prst_pkg::CODE_SPAN);
    endfunction

    task automatic report_and_stop();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp_word(input string what, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_item(input prst_pkg::prst_item_type e,
        input prst_pkg::prst_item_type g);
        prst_pkg::prst_item_type m;
        m = '1;
        // Code and direction mean nothing on carriage moves
        if (e.kind != prst_pkg::KIND_CHAR) begin
            m.code = 7'h00;
            m.reverse = 1'b0;
        end
        tests_run++;
        if ((g & m) !== (e & m)) begin
            fails++;
            $display("Error item expected %h seen %h", e, g);
        end
    endtask
    task automatic exp_next(output prst_pkg::prst_item_type e);
        e.kind = prst_pkg::KIND_CHAR;
        e.code = wrap_code(e_rev ? int'(e_start) + ncols - 1 - e_col
            : int'(e_start) + e_col);
        e.reverse = e_rev;
        e.compressed = pitch_select_switch;
        e.alt_set = glyph_table_select_switch;
        e.lpi8 = line_spacing_switch;
        e.wide = e_wide;
        if (e_col < ncols) begin
            e_col++;
        end else begin
            e_col = 0;
            e_rev = !e_rev;
            if (e_over && e_line % 2 == 1 && e_pass < 32) begin
                e.kind = prst_pkg::KIND_RETURN;
                e_pass++;
            end else begin
                e.kind = prst_pkg::KIND_FEED;
                e_pass = 0;
                e_line++;
                e_start = wrap_code(int'(e_start) + 1);
            end
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] wd, output logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        // Only the bench watchdog ends a wait
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic toggle();
        diag_run_overprint_switch.run_toggle <= 1'b1;
        repeat (2) @(posedge mclk);
        diag_run_overprint_switch.run_toggle <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        if (checking && item_valid === 1'b1 && item_ready === 1'b1) begin
            exp_next(ex);
            cmp_item(ex, item_data);
            got++;
        end
    end

    initial begin
        repeat (30000) @(posedge mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        int nt;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        bus(1'b0, prst_pkg::OFS_CTRL, 32'h0, rd);
        cmp_word("ctrl", 32'h1, rd);
        bus(1'b1, prst_pkg::OFS_STATUS, 32'hffff, rd);
        bus(1'b0, prst_pkg::OFS_STATUS, 32'h0, rd);
        cmp_word("status", 32'h1, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        cmp_word("unmapped", 32'h0, rd);
        for (int k = 0; k < 4; k++) begin
            online_switch <= 1'b0;
            master_clear_button <= 1'b1;
            repeat (2) @(posedge mclk);
            master_clear_button <= 1'b0;
            @(posedge mclk);
            cmp_word("active", 32'h0, {31'h0, test_active});
            online_switch <= 1'b1;
            toggle();
            cmp_word("unarmed", 32'h0, {31'h0, test_active});
            online_switch <= 1'b0;
            rnd = xs(rnd);
            pitch_select_switch <= k[0];
            glyph_table_select_switch <= rnd[0];
            line_spacing_switch <= rnd[1];
            diag_run_overprint_switch.overprint_pos <= k[0];
            nt = (k >= 2) ? 2 : 1;
            repeat (nt) toggle();
            bus(1'b0, prst_pkg::OFS_STATUS, 32'h0, rd);
            // Width bit latches only on going online
            cmp_word("armed", {25'h0, k[0], 2'(nt), 4'h2}, rd);
            e_start = prst_pkg::CODE_FIRST;
            e_rev = 1'b0;
            e_col = 0;
            e_line = 0;
            e_pass = 0;
            e_over = k[0];
            e_wide = (nt == 2);
            ncols = (k == 0) ? C_NN : (k == 1) ? C_NC : (k == 2) ? C_WN : C_WC;
            got = 0;
            hold_off <= 1'b1;
            checking <= 1'b1;
            online_switch <= 1'b1;
            repeat (40) @(posedge mclk);
            bus(1'b0, prst_pkg::OFS_STATUS, 32'h0, rd);
            cmp_word("level", 32'h10, {27'h0, rd[16:12]});
            hold_off <= 1'b0;
            while (got < 450) @(posedge mclk);
            bus(1'b1, prst_pkg::OFS_CTRL, 32'h0, rd);
            repeat (3) @(posedge mclk);
            while (item_valid !== 1'b0) @(posedge mclk);
            checking <= 1'b0;
            bus(1'b0, prst_pkg::OFS_LINES, 32'h0, rd);
            cmp_word("lines", 32'(e_line), {16'h0, rd[15:0]});
            bus(1'b0, prst_pkg::OFS_POSITION, 32'h0, rd);
            cmp_word("start", {25'h0, e_start}, {25'h0, rd[6:0]});
            bus(1'b0, prst_pkg::OFS_CTRL, 32'h0, rd);
            cmp_word("paused", 32'h0, rd);
            bus(1'b1, prst_pkg::OFS_CTRL, 32'h1, rd);
        end
        bus(1'b1, prst_pkg::OFS_CTRL, 32'h3, rd);
        repeat (2) @(posedge mclk);
        cmp_word("cleared", 32'h0, {31'h0, test_active});
        bus(1'b0, prst_pkg::OFS_STATUS, 32'h0, rd);
        cmp_word("idle", 32'h1, {28'h0, rd[3:0]});
        report_and_stop();
    end
endmodule

bind prst_self_test prst_checker prst_checker_i (.mclk(mclk),
    .sys_rst(sys_rst), .master_clear_button(master_clear_button),
    .online_switch(online_switch), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .item_valid(item_valid), .item_ready(item_ready),
    .item_data(item_data), .test_active(test_active));
